// ---- hdl/bus_tag_pkg.sv ----
// Package: constants for the bus tag and direction block
package bus_tag_pkg;
    localparam int AD_W         = 32;
    localparam int TAG_W        = 3;
    localparam int SEL_W        = 2;
    // Master read: direction asserted for the first two cycles
    localparam logic [1:0] READ_DIR_CYCLES = 2'h2;
    // Tag encodings
    localparam logic [2:0] TAG_IO_SPACE  = 3'h4;
    localparam logic [2:0] TAG_SLAVE_IO  = 3'h7;
    localparam logic       TAG_UNMAPPED_MSB = 1'h0;
    // Direction pin idle level (toward unit)
    localparam logic       DIR_IDLE = 1'h1;
    localparam logic [3:0] RESET_PHASE = 4'h0;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_WDATA, ST_RDATA, ST_SLAVE
    } phase_e;
endpackage

// ---- hdl/word_buffer.sv ----
// Two-entry word buffer with valid/ready on both sides
`timescale 1ns/100ps
module word_buffer
    import bus_tag_pkg::*;
(
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst,
    // Fill side
    input  wire logic              in_valid,
    input  wire logic [AD_W-1:0]   in_data,
    output logic                   in_ready,
    // Drain side
    output logic                   out_valid,
    output logic [AD_W-1:0]        out_data,
    input  wire logic              out_ready
);
    logic [AD_W-1:0] mem_r [2];
    logic [AD_W-1:0] mem_nxt [2];
    logic            wr_r, wr_nxt;
    logic            rd_r, rd_nxt;
    logic [1:0]      cnt_r, cnt_nxt;
    logic            push, pop;

    always_comb
    begin
        push      = in_valid && (cnt_r != 2'h2);
        pop       = out_ready && (cnt_r != 2'h0);
        mem_nxt   = mem_r;
        wr_nxt    = wr_r;
        rd_nxt    = rd_r;
        if (push)
        begin
            mem_nxt[wr_r] = in_data;
            wr_nxt        = ~wr_r;
        end
        if (pop)
        begin
            rd_nxt = ~rd_r;
        end
        cnt_nxt = cnt_r + {1'h0, push} - {1'h0, pop};
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            wr_r  <= 1'h0;
            rd_r  <= 1'h0;
            cnt_r <= 2'h0;
        end
        else
        begin
            wr_r  <= wr_nxt;
            rd_r  <= rd_nxt;
            cnt_r <= cnt_nxt;
        end
        mem_r <= mem_nxt;
    end

    assign in_ready  = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data  = mem_r[rd_r];
endmodule

// ---- hdl/bus_tag_dir.sv ----
// Top: address/data path, direction control and space tag
`timescale 1ns/100ps
//
// Notes on behaviour
// - Address and data share 32 positive-logic two-way lines in time.
// - As master, direction is low for a whole write, two read cycles.
// - A data-side slave holds direction low while driving I/O read data.
// - An instruction-side slave holds direction low sending to its peer.
// - Direction low means the unit drives toward the bus.
// - A three-bit space tag is driven with every access.
// - In mapped mode the tag comes from the translation result.
// - In unmapped mode tag bit 2 is zero, low bits from the select bits.
// - Tag value 4 marks noncacheable I/O space.
// - In a slave I/O read the words read are discarded by the unit.
module bus_tag_dir
(
    // Clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    // Access request
    input  wire logic                      req_valid,
    output logic                           req_ready,
    input  wire logic                      req_write,
    input  wire logic [bus_tag_pkg::AD_W-1:0] req_addr,
    input  wire logic [bus_tag_pkg::AD_W-1:0] req_wdata,
    input  wire logic                      req_last,
    // Tag sources
    input  wire logic                      mapped_mode,
    input  wire logic [bus_tag_pkg::TAG_W-1:0] xlate_tag,
    input  wire logic [bus_tag_pkg::SEL_W-1:0] unmapped_tag_select,
    // Slave transfers
    input  wire logic                      slave_req,
    input  wire logic                      is_data_side,
    input  wire logic                      slave_io_read,
    input  wire logic [bus_tag_pkg::AD_W-1:0] slave_data,
    // Read data and I/O space flag to the processor side
    output logic                           rd_valid,
    output logic [bus_tag_pkg::AD_W-1:0]   rd_data,
    input  wire logic                      rd_ready,
    output logic                           io_space,
    // Bus pins
    input  wire logic [bus_tag_pkg::AD_W-1:0] ad_in,
    output logic [bus_tag_pkg::AD_W-1:0]   ad_out,
    output logic                           ad_oe,
    output logic [bus_tag_pkg::TAG_W-1:0]  space_tag,
    output logic                           dir_n
);
    import bus_tag_pkg::*;

    // ------------------------------------------------------------
    // Bus phase sequencer
    // ------------------------------------------------------------
    phase_e          phase_r, phase_nxt;
    logic [1:0]      rcnt_r, rcnt_nxt;
    logic [AD_W-1:0] ad_r, ad_nxt;
    logic            oe_r, oe_nxt;
    logic [TAG_W-1:0] tag_r, tag_nxt;
    logic            dir_r, dir_nxt;
    logic            io_r, io_nxt;
    logic            rdv_nxt;
    logic            buf_ready;
    logic [TAG_W-1:0] cur_tag;

    always_comb
    begin
        // Space tag from translation or unmapped selection
        // mapped source
        if (mapped_mode)
            cur_tag = xlate_tag;
        else
            cur_tag = {TAG_UNMAPPED_MSB, unmapped_tag_select};
        phase_nxt = phase_r;
        rcnt_nxt  = rcnt_r;
        ad_nxt    = ad_r;
        oe_nxt    = 1'h0;
        tag_nxt   = tag_r;
        dir_nxt   = DIR_IDLE;
        io_nxt    = io_r;
        rdv_nxt   = 1'h0;
        req_ready = 1'h0;
        case (phase_r)
            ST_IDLE:
            begin
                if (slave_req)
                    phase_nxt = ST_SLAVE;
                else if (req_valid)
                begin
                    req_ready = 1'h1;
                    tag_nxt   = cur_tag;
                    io_nxt    = (cur_tag == TAG_IO_SPACE);
                    ad_nxt    = req_addr;
                    oe_nxt    = 1'h1;
                    dir_nxt   = 1'h0;
                    rcnt_nxt  = 2'h1;
                    phase_nxt = req_write ? ST_WDATA : ST_RDATA;
                end
            end
            ST_WDATA:
            begin
                dir_nxt = 1'h0;
                oe_nxt  = 1'h1;
                if (req_valid)
                begin
                    req_ready = 1'h1;
                    ad_nxt    = req_wdata;
                    if (req_last)
                        phase_nxt = ST_ADDR;
                end
            end
            ST_ADDR:
            begin
                // Last write word still on the lines this cycle
                phase_nxt = ST_IDLE;
            end
            ST_RDATA:
            begin
                if (rcnt_r < READ_DIR_CYCLES)
                begin
                    dir_nxt  = 1'h0;
                    rcnt_nxt = rcnt_r + 2'h1;
                end
                if (tag_r != TAG_SLAVE_IO)
                    rdv_nxt = req_valid && buf_ready;
                if (req_valid && buf_ready)
                begin
                    req_ready = 1'h1;
                    if (req_last)
                        phase_nxt = ST_IDLE;
                end
            end
            ST_SLAVE:
            begin
                if (slave_req &&
                    ((is_data_side && slave_io_read) || !is_data_side))
                begin
                    dir_nxt = 1'h0;
                    oe_nxt  = 1'h1;
                    ad_nxt  = slave_data;
                end
                else
                    phase_nxt = ST_IDLE;
            end
            default:
                phase_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            phase_r <= ST_IDLE;
            rcnt_r  <= 2'h0;
            ad_r    <= '0;
            oe_r    <= 1'h0;
            tag_r   <= '0;
            dir_r   <= DIR_IDLE;
            io_r    <= 1'h0;
        end
        else
        begin
            phase_r <= phase_nxt;
            rcnt_r  <= rcnt_nxt;
            ad_r    <= ad_nxt;
            oe_r    <= oe_nxt;
            tag_r   <= tag_nxt;
            dir_r   <= dir_nxt;
            io_r    <= io_nxt;
        end
    end

    // ------------------------------------------------------------
    // Read data buffer and registered outputs
    // ------------------------------------------------------------
    logic            bv;
    logic [AD_W-1:0] bd;
    logic            rdv_r;
    logic [AD_W-1:0] rdd_r;

    // Buffer absorbs stalls so no bus word is lost
    word_buffer u_buf (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .in_valid  (rdv_nxt),
        .in_data   (ad_in),
        .in_ready  (buf_ready),
        .out_valid (bv),
        .out_data  (bd),
        .out_ready (rd_ready || !rdv_r)
    );

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            rdv_r <= 1'h0;
            rdd_r <= '0;
        end
        else if (rd_ready || !rdv_r)
        begin
            rdv_r <= bv;
            rdd_r <= bd;
        end
    end

    assign ad_out    = ad_r;
    assign ad_oe     = oe_r;
    assign space_tag = tag_r;
    assign dir_n     = dir_r;
    assign io_space  = io_r;
    assign rd_valid  = rdv_r;
    assign rd_data   = rdd_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence read_start;
        phase_r == ST_IDLE && req_valid && !slave_req && !req_write;
    endsequence

    read_dir_two_a: assert property (@(posedge sys_clk) disable iff (rst)
        read_start ##1 1 |-> !dir_n ##1 !dir_n)
        else $error("read direction not low two cycles");
    write_dir_low_a: assert property (@(posedge sys_clk) disable iff (rst)
        phase_r == ST_WDATA |=> !dir_n)
        else $error("write direction not low");
    drive_dir_a: assert property (@(posedge sys_clk) disable iff (rst)
        ad_oe |-> !dir_n)
        else $error("driving with direction high");
    unmapped_tag_a: assert property (@(posedge sys_clk) disable iff (rst)
        phase_r == ST_IDLE && req_valid && !slave_req && !mapped_mode
        |=> space_tag == {1'b0, $past(unmapped_tag_select)})
        else $error("unmapped tag wrong");
    mapped_tag_a: assert property (@(posedge sys_clk) disable iff (rst)
        phase_r == ST_IDLE && req_valid && !slave_req && mapped_mode
        |=> space_tag == $past(xlate_tag))
        else $error("mapped tag wrong");
    io_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
        phase_r != ST_IDLE && phase_r != ST_SLAVE
        |-> io_space == (space_tag == TAG_IO_SPACE))
        else $error("I/O space flag wrong");
    // Buffer fill must not grow while a slave I/O read runs
    slave_io_drop_a: assert property (@(posedge sys_clk) disable iff (rst)
        phase_r == ST_RDATA && tag_r == TAG_SLAVE_IO
        |=> u_buf.cnt_r <= $past(u_buf.cnt_r))
        else $error("slave I/O data kept");
    idle_dir_a: assert property (@(posedge sys_clk) disable iff (rst)
        phase_r == ST_IDLE && !req_valid && !slave_req |=> dir_n)
        else $error("direction low when idle");
endmodule

// ---- verif/bus_far_side.sv ----
// Far-side bus model: memory word source and slave I/O capture
`timescale 1ns/100ps
module bus_far_side
    import bus_tag_pkg::*;
(
    // Clock
    input  wire logic              sys_clk,
    // Unit side of the transceivers
    input  wire logic [AD_W-1:0]   ad_out,
    input  wire logic              dir_n,
    input  wire logic [TAG_W-1:0]  space_tag,
    output logic [AD_W-1:0]        ad_in,
    // Words seen by the I/O device
    output int                     io_captures
);
    logic [AD_W-1:0] mem_r;

    initial
    begin
        mem_r = 32'hA5A5_0F0F;
        io_captures = 0;
    end
    assign ad_in = dir_n ? mem_r : ad_out;
    // New word every cycle, so a stale sample never passes
    always @(posedge sys_clk)
    begin
        mem_r <= {mem_r[30:0], mem_r[31] ^ mem_r[21]} ^ 32'h0000_1357;
        if (dir_n && space_tag == TAG_SLAVE_IO)
            io_captures <= io_captures + 1;
    end
endmodule

// ---- verif/bus_tag_dir_tb_top.sv ----
// Testbench: random and corner accesses against the far-side model
`timescale 1ns/100ps
module bus_tag_dir_tb_top;
    import bus_tag_pkg::*;
    logic             sys_clk, rst, req_valid, req_ready, req_write;
    logic             req_last, mapped_mode, slave_req, is_data_side;
    logic             slave_io_read, rd_valid, rd_ready, io_space;
    logic             ad_oe, dir_n, stall;
    logic [AD_W-1:0]  req_addr, req_wdata, slave_data, rd_data, ad_in;
    logic [AD_W-1:0]  ad_out;
    logic [TAG_W-1:0] xlate_tag, space_tag;
    logic [SEL_W-1:0] unmapped_tag_select;
    logic [31:0]      seed;
    logic [AD_W-1:0]  rq[$];
    int               n_mismatch, samples_checked, io_captures;

    bus_tag_dir dut_u (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_last(req_last),
        .mapped_mode(mapped_mode), .xlate_tag(xlate_tag),
        .unmapped_tag_select(unmapped_tag_select), .slave_req(slave_req),
        .is_data_side(is_data_side), .slave_io_read(slave_io_read),
        .slave_data(slave_data), .rd_valid(rd_valid), .rd_data(rd_data),
        .rd_ready(rd_ready), .io_space(io_space), .ad_in(ad_in),
        .ad_out(ad_out), .ad_oe(ad_oe), .space_tag(space_tag),
        .dir_n(dir_n));
    bus_far_side far_u (.sys_clk(sys_clk), .ad_out(ad_out), .dir_n(dir_n),
        .space_tag(space_tag), .ad_in(ad_in), .io_captures(io_captures));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input logic [AD_W-1:0] seen,
                         input logic [AD_W-1:0] want);
        samples_checked++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("unexpected at %0t: seen %0h expected %0h",
                     $time, seen, want);
        end
    endtask
    task automatic final_report();
        $display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // One access: address, then n words
    task automatic access(input logic wr, input int n,
                          input logic [AD_W-1:0] a);
        int               k, g, e;
        logic             tk;
        logic [AD_W-1:0]  w;
        logic [TAG_W-1:0] t;
        t = mapped_mode ? xlate_tag : {TAG_UNMAPPED_MSB, unmapped_tag_select};
        k = 0;
        g = 0;
        e = 0;
        w = a;
        req_valid <= 1'h1;
        req_write <= wr;
        req_addr  <= a;
        req_last  <= 1'h0;
        req_wdata <= rnd();
        while (k <= n && g < 100)
        begin
            @(posedge sys_clk);
            g++;
            tk = req_ready === 1'h1;
            if (e > 0)
                e++;
            if (tk)
            begin
                if (k == 0)
                    e = 1;
                else
                    w = req_wdata;
                if (!wr && k > 0 && t != TAG_SLAVE_IO)
                    rq.push_back(ad_in);
                k++;
                req_last  <= (k == n);
                req_wdata <= rnd();
                if (k > n)
                    req_valid <= 1'h0;
            end
            #1;
            if (tk && (wr || e == 1))
                check(ad_out, w);
            if (e == 1)
                check(space_tag, t);
            if (e == 1)
                check(io_space, t == TAG_IO_SPACE);
            if (e > 0)
                check(dir_n, wr ? 1'h0 : e > 2);
        end
        // Limit ran out: the access never completed
        if (k <= n)
            check(k, n + 1);
        repeat (3) @(posedge sys_clk);
        #1;
        check(dir_n, DIR_IDLE);
        check(ad_oe, 1'h0);
    endtask

    initial
    begin
        sys_clk = 1'h0;
        forever #4 sys_clk = ~sys_clk;
    end
    // Unit drives the lines only with direction toward the bus
    always @(negedge sys_clk)
        if (ad_oe === 1'h1)
            check(dir_n, 1'h0);
    // Consumer with random stalls
    always @(posedge sys_clk)
    begin
        rd_ready <= !stall && rnd() % 3 != 0;
        if (rd_valid === 1'h1 && rd_ready === 1'h1)
            if (rq.size() == 0)
                check(rd_valid, 1'h0);
            else
                check(rd_data, rq.pop_front());
    end
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        final_report();
    end
    initial
    begin
        seed = 32'hC24C8984;
        {rst, stall} = 2'h2;
        {req_valid, req_write, req_last, mapped_mode, slave_req} = 5'h0;
        {is_data_side, slave_io_read, rd_ready} = 3'h0;
        {req_addr, req_wdata, slave_data} = '0;
        {xlate_tag, unmapped_tag_select} = 5'h0;
        n_mismatch = 0;
        samples_checked = 0;
        repeat (20) @(posedge sys_clk);
        rst <= 1'h0;
        @(posedge sys_clk);
        #1;
        check(dir_n, DIR_IDLE);
        // Every mapped tag, then every unmapped select
        for (int i = 0; i < 12; i++)
        begin
            @(posedge sys_clk);
            mapped_mode         <= i < 8;
            xlate_tag           <= i[2:0];
            unmapped_tag_select <= i[1:0];
            @(posedge sys_clk);
            access((i == 4 || i == 7) ? 1'h0 : rnd() % 2 == 1,
                   1 + rnd() % 4, rnd());
        end
        repeat (20) @(posedge sys_clk);
        check(io_captures > 0, 1'h1);
        check(rq.size(), 0);
        $display("tag and direction test done");
        // Consumer stalls: the buffer must refuse before six words
        stall <= 1'h1;
        fork
            access(1'h0, 6, rnd());
        join_none
        repeat (30) @(posedge sys_clk);
        check(rq.size() < 6, 1'h1);
        stall <= 1'h0;
        wait fork;
        repeat (20) @(posedge sys_clk);
        check(rq.size(), 0);
        $display("buffer stall test done");
        for (int i = 0; i < 4; i++)
        begin
            @(posedge sys_clk);
            slave_req     <= 1'h1;
            is_data_side  <= i[0];
            slave_io_read <= i[1];
            slave_data    <= rnd();
            repeat (2) @(posedge sys_clk);
            #1;
            check(dir_n, i[0] && !i[1]);
            if (!(i[0] && !i[1]))
                check(ad_out, slave_data);
            @(posedge sys_clk);
            slave_req <= 1'h0;
            repeat (2) @(posedge sys_clk);
            #1;
            check(dir_n, DIR_IDLE);
        end
        $display("slave transfer test done");
        final_report();
    end
endmodule
